// *** design/spi_core_pkg.sv ***
// constants, register map and state type shared by the serial core files
package spi_core_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] POLY_OFS = 8'h0c;
  localparam logic [7:0] RXCRC_OFS = 8'h10;
  localparam logic [7:0] TXCRC_OFS = 8'h14;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int CLOCK_PHASE_B = 0;
  localparam int CLOCK_POLARITY_B = 1;
  localparam int MASTER_SELECT_B = 2;
  localparam int BR_LSB = 3;
  localparam int SPE_B = 6;
  localparam int LSB_B = 7;
  localparam int SSI_B = 8;
  localparam int SSM_B = 9;
  localparam int BIDI_B = 10;
  localparam int DFF_B = 11;
  localparam int CRCEN_B = 12;
  localparam int CRCNXT_B = 13;
  localparam int BIDIOE_B = 14;
  localparam int SELECT_OUTPUT_ENABLE_B = 15;
  localparam int TXDMA_B = 16;
  localparam int RXDMA_B = 17;
  localparam int ERRIE_B = 18;
  localparam int RXIE_B = 19;
  localparam int TXIE_B = 20;
  localparam int CTRL_W = 21;
  localparam logic [20:0] CTRL_RST = 21'h000000;
  // ----------------------------------------
  // status field positions and resets
  // ----------------------------------------
  localparam int RX_BUFFER_FULL_FLAG_B = 0;
  localparam int TXE_B = 1;
  localparam int CRCERR_B = 4;
  localparam int MODF_B = 5;
  localparam int OVR_B = 6;
  localparam int BSY_B = 7;
  localparam logic [15:0] POLY_RST = 16'h0007;
  localparam logic [4:0] FRAME_SHORT = 5'h08;
  localparam logic [4:0] FRAME_LONG = 5'h10;
  localparam logic [7:0] BAUD_HALF_MIN = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // pin synchroniser slots
  // ----------------------------------------
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_NSS = 3;
  localparam logic [3:0] PIN_RST = 4'h8;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1} xfer_state_e;
endpackage

// *** design/spi_baud_gen.sv ***
// master serial clock half-period tick generator
`timescale 1ns/100ps
`default_nettype none
module spi_baud_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] half;
  // ----------------------------------------
  // divide by 2, 4 .. 256: half period is 1 << sel cycles
  // ----------------------------------------
  assign half = spi_core_pkg::BAUD_HALF_MIN << sel;
  assign tick = run && (cnt_q == half - spi_core_pkg::BAUD_HALF_MIN);
  always_comb begin
    cnt_d = cnt_q + spi_core_pkg::BAUD_HALF_MIN;
    if (!run || tick) begin
      cnt_d = '0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// *** design/spi_crc_calc.sv ***
// bit-serial crc over 8- or 16-bit frames
`timescale 1ns/100ps
`default_nettype none
module spi_crc_calc (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic step,
  input wire logic bit_in,
  input wire logic wide,
  input wire logic [15:0] poly,
  output logic [15:0] crc
);
  logic [15:0] crc_d;
  logic fb;
  // ----------------------------------------
  // one bit per sampling edge, in line order
  // ----------------------------------------
  always_comb begin
    fb = (wide ? crc[15] : crc[7]) ^ bit_in;
    crc_d = crc;
    if (step) begin
      crc_d = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
      if (!wide) begin
        crc_d[15:8] = 8'h00;
      end
    end
    if (clr) begin
      crc_d = 16'h0000;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc <= 16'h0000;
    end else begin
      crc <= crc_d;
    end
  end
endmodule
`default_nettype wire

// *** design/spi_serial_core.sv ***
// serial peripheral core with axi4-lite registers, master and slave engine
// What this block does
// - frames are 8 or 16 bits, picked by the frame width bit
// - bit order msb-first or lsb-first per the bit-order bit
// - serial clock idles low with polarity clear, high with it set
// - phase set: capture on the second clock edge of each bit
// - phase clear: capture on the first clock edge of each bit
// - soft select: internal level replaces the select pin
// - hardware select output in master drives select low until disabled
// - hardware select input: slave selected while low, allows multimaster
// - master with select input low: mode fault, drop to slave
// - master drives clock and mosi; slave drives miso
// - master starts every transfer; both shift simultaneously on its clock
// - eight master baud settings, fastest half the bus clock
// - two-line simplex with optional bidirectional line, or full duplex
// - hardware crc, optionally sent last, checked on last word
// - mode fault, overrun, crc error flags with irq; busy flag
// - one-word tx and rx buffers, each with a dma request
// - tx empty flag sets when the buffer moves to the shifter
// - frame end fills rx buffer unless still full (overrun) and sets rx full; data read clears
// - slave rate follows the outside clock, not the baud setting
`timescale 1ns/100ps
`default_nettype none
module spi_serial_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic nss_i,
  output logic nss_o,
  output logic nss_oe,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic pick_bit(input logic [15:0] s, input logic w, input logic l);
    pick_bit = l ? s[0] : (w ? s[15] : s[7]);
  endfunction
  function automatic logic [15:0] shift_tx(input logic [15:0] s, input logic l);
    shift_tx = l ? {1'b0, s[15:1]} : {s[14:0], 1'b0};
  endfunction
  function automatic logic [15:0] rx_word(input logic [15:0] s, input logic w, input logic l);
    rx_word = w ? s : (l ? {8'h00, s[15:8]} : {8'h00, s[7:0]});
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = b[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [20:0] ctrl_q, ctrl_d;
  logic [15:0] tx_buf_q, tx_buf_d, rx_buf_q, rx_buf_d, poly_q, poly_d;
  logic rx_buffer_full_flag_q, rx_buffer_full_flag_d, txe_q, txe_d, crcerr_q, crcerr_d;
  logic modf_q, modf_d, ovr_q, ovr_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wbuf_q, wbuf_d, rdata_d, cmerge;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic do_wr, rd_data;
  logic [3:0] pin_s1_q, pin_s2_q;
  spi_core_pkg::xfer_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d, width;
  logic [15:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, load_word, rx_new;
  logic sck_q, sck_d, out_q, out_d, sck_prev_q, crc_frame_q, crc_frame_d;
  logic nss_act_q, nss_act_d, nss_o_q, sck_oe_q, mosi_oe_q, miso_oe_q;
  logic tx_dma_q, rx_dma_q, irq_q, bsy;
  logic en, mst, clock_phase, clock_polarity, wide, lsb, bidi, drv_ok, crc_en, crc_next;
  logic sel_lvl, slave_sel, hw_out, modf_ev, rx_line, sck_s, tick, mst_run;
  logic slv_edge, lead, trail, sample, present, stop, done_ev, master_go;
  logic load_ev, load_buf, ovr_set, crc_bad;
  logic [15:0] tx_crc, rx_crc;
  // ----------------------------------------
  // control decode
  // ----------------------------------------
  assign en = ctrl_q[spi_core_pkg::SPE_B];
  assign mst = ctrl_q[spi_core_pkg::MASTER_SELECT_B];
  assign clock_phase = ctrl_q[spi_core_pkg::CLOCK_PHASE_B];
  assign clock_polarity = ctrl_q[spi_core_pkg::CLOCK_POLARITY_B];
  assign wide = ctrl_q[spi_core_pkg::DFF_B];
  assign lsb = ctrl_q[spi_core_pkg::LSB_B];
  assign bidi = ctrl_q[spi_core_pkg::BIDI_B];
  assign crc_en = ctrl_q[spi_core_pkg::CRCEN_B];
  assign crc_next = ctrl_q[spi_core_pkg::CRCNXT_B] && crc_en;
  assign width = wide ? spi_core_pkg::FRAME_LONG : spi_core_pkg::FRAME_SHORT;
  assign drv_ok = !bidi || ctrl_q[spi_core_pkg::BIDIOE_B];
  assign sel_lvl = ctrl_q[spi_core_pkg::SSM_B] ? ctrl_q[spi_core_pkg::SSI_B]
                 : pin_s2_q[spi_core_pkg::PIN_NSS];
  assign hw_out = !ctrl_q[spi_core_pkg::SSM_B] && ctrl_q[spi_core_pkg::SELECT_OUTPUT_ENABLE_B];
  assign slave_sel = en && !mst && !sel_lvl;
  assign modf_ev = en && mst && !hw_out && !sel_lvl;
  assign sck_s = pin_s2_q[spi_core_pkg::PIN_SCK];
  // bidirectional mode listens on the line this end would otherwise drive
  assign rx_line = mst == bidi ? pin_s2_q[spi_core_pkg::PIN_MOSI]
                 : pin_s2_q[spi_core_pkg::PIN_MISO];
  // ----------------------------------------
  // edge events
  // ----------------------------------------
  assign mst_run = mst && (state_q == spi_core_pkg::ST_RUN);
  // slave edges are seen after the synchroniser, so bus clock must exceed twice sck
  assign slv_edge = !mst && (state_q == spi_core_pkg::ST_RUN) && slave_sel
                    && (sck_s != sck_prev_q);
  assign lead = mst ? (mst_run && tick && (sck_q == clock_polarity)) : (slv_edge && (sck_s != clock_polarity));
  assign trail = mst ? (mst_run && tick && (sck_q != clock_polarity)) : (slv_edge && (sck_s == clock_polarity));
  assign sample = clock_phase ? trail : lead;
  assign present = clock_phase ? lead : trail;
  assign stop = trail && (cnt_q == (clock_phase ? width - 5'h01 : width));
  assign done_ev = sample && (cnt_q == width - 5'h01);
  assign master_go = en && mst && !modf_ev && (!txe_q || crc_next);
  assign load_buf = load_ev && !crc_next;
  assign rx_new = rx_word(rx_sh_d, wide, lsb);
  assign crc_bad = done_ev && crc_frame_q && (rx_new != rx_crc);
  assign bsy = (state_q != spi_core_pkg::ST_IDLE) || (en && mst && !txe_q);
  spi_baud_gen u_baud (
    .clk(clk),
    .rst(rst),
    .run(mst_run),
    .sel(ctrl_q[spi_core_pkg::BR_LSB +: 3]),
    .tick(tick)
  );
  spi_crc_calc u_tx_crc (
    .clk(clk),
    .rst(rst),
    .clr(!crc_en || !en),
    .step(sample && crc_en && !crc_frame_q),
    .bit_in(out_q),
    .wide(wide),
    .poly(poly_q),
    .crc(tx_crc)
  );
  spi_crc_calc u_rx_crc (
    .clk(clk),
    .rst(rst),
    .clr(!crc_en || !en),
    .step(sample && crc_en && !crc_frame_q),
    .bit_in(rx_line),
    .wide(wide),
    .poly(poly_q),
    .crc(rx_crc)
  );
  // ----------------------------------------
  // shift engine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    sck_d = sck_q;
    out_d = out_q;
    crc_frame_d = crc_frame_q;
    nss_act_d = nss_act_q;
    load_ev = 1'b0;
    load_word = crc_next ? tx_crc : tx_buf_q;
    if (sample) begin
      rx_sh_d = lsb ? {rx_line, rx_sh_q[15:1]} : {rx_sh_q[14:0], rx_line};
      cnt_d = cnt_q + 5'h01;
    end
    if (present) begin
      out_d = pick_bit(tx_sh_q, wide, lsb);
      tx_sh_d = shift_tx(tx_sh_q, lsb);
    end
    if (mst_run && tick) begin
      sck_d = !sck_q;
    end
    unique case (state_q)
      spi_core_pkg::ST_IDLE: begin
        sck_d = clock_polarity;
        cnt_d = '0;
        if (master_go || slave_sel) begin
          state_d = spi_core_pkg::ST_RUN;
          load_ev = 1'b1;
        end
      end
      spi_core_pkg::ST_RUN: begin
        if (stop) begin
          cnt_d = '0;
          if (mst) begin
            state_d = spi_core_pkg::ST_IDLE;
          end else begin
            load_ev = 1'b1;
          end
        end
      end
    endcase
    if (load_ev) begin
      tx_sh_d = load_word;
      crc_frame_d = crc_next;
      if (!clock_phase) begin
        // with phase clear the first bit must be on the line before the first edge
        out_d = pick_bit(load_word, wide, lsb);
        tx_sh_d = shift_tx(load_word, lsb);
      end
      if (mst && hw_out) begin
        nss_act_d = 1'b1;
      end
    end
    if (!en || modf_ev || (!mst && !slave_sel)) begin
      state_d = spi_core_pkg::ST_IDLE;
      cnt_d = '0;
      sck_d = clock_polarity;
    end
    if (!en || !hw_out || !mst) begin
      nss_act_d = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= spi_core_pkg::PIN_RST;
      pin_s2_q <= spi_core_pkg::PIN_RST;
      sck_prev_q <= 1'b0;
      state_q <= spi_core_pkg::ST_IDLE;
      cnt_q <= '0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
      sck_q <= 1'b0;
      out_q <= 1'b0;
      crc_frame_q <= 1'b0;
      nss_act_q <= 1'b0;
      nss_o_q <= 1'b1;
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      tx_dma_q <= 1'b0;
      rx_dma_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pin_s1_q <= {nss_i, miso_i, mosi_i, sck_i};
      pin_s2_q <= pin_s1_q;
      sck_prev_q <= sck_s;
      state_q <= state_d;
      cnt_q <= cnt_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      sck_q <= sck_d;
      out_q <= out_d;
      crc_frame_q <= crc_frame_d;
      nss_act_q <= nss_act_d;
      nss_o_q <= !nss_act_d;
      sck_oe_q <= en && mst;
      mosi_oe_q <= en && mst && drv_ok;
      miso_oe_q <= slave_sel && drv_ok;
      tx_dma_q <= ctrl_d[spi_core_pkg::TXDMA_B] && txe_d;
      rx_dma_q <= ctrl_d[spi_core_pkg::RXDMA_B] && rx_buffer_full_flag_d;
      irq_q <= (ctrl_d[spi_core_pkg::ERRIE_B] && (crcerr_d || modf_d || ovr_d))
            || (ctrl_d[spi_core_pkg::RXIE_B] && rx_buffer_full_flag_d) || (ctrl_d[spi_core_pkg::TXIE_B] && txe_d);
    end
  end
  // ----------------------------------------
  // axi4-lite slave and register file
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    tx_buf_d = tx_buf_q;
    rx_buf_d = rx_buf_q;
    poly_d = poly_q;
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    waddr_d = waddr_q;
    wbuf_d = wbuf_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid;
    bresp_d = bresp;
    rvalid_d = rvalid;
    rresp_d = rresp;
    rdata_d = rdata;
    rd_data = 1'b0;
    cmerge = merge({11'h000, ctrl_q}, wbuf_q, wstrb_q);
    do_wr = aw_full_q && w_full_q && !bvalid;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      wbuf_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid && rready) begin
      rvalid_d = 1'b0;
    end
    if (load_ev && crc_next) begin
      ctrl_d[spi_core_pkg::CRCNXT_B] = 1'b0;
    end
    txe_d = txe_q;
    crcerr_d = crcerr_q;
    modf_d = modf_q;
    ovr_d = ovr_q;
    if (do_wr) begin
      bvalid_d = 1'b1;
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bresp_d = spi_core_pkg::RESP_OKAY;
      unique case (waddr_q)
        spi_core_pkg::CTRL_OFS: ctrl_d = cmerge[spi_core_pkg::CTRL_W-1:0];
        spi_core_pkg::DATA_OFS: begin
          tx_buf_d = 16'(merge({16'h0000, tx_buf_q}, wbuf_q, wstrb_q));
          txe_d = 1'b0;
        end
        spi_core_pkg::POLY_OFS: poly_d = wbuf_q[15:0];
        spi_core_pkg::STAT_OFS: begin
          crcerr_d = crcerr_q && !wbuf_q[spi_core_pkg::CRCERR_B];
          modf_d = modf_q && !wbuf_q[spi_core_pkg::MODF_B];
          ovr_d = ovr_q && !wbuf_q[spi_core_pkg::OVR_B];
        end
        spi_core_pkg::RXCRC_OFS, spi_core_pkg::TXCRC_OFS: bresp_d = spi_core_pkg::RESP_OKAY;
        default: bresp_d = spi_core_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = spi_core_pkg::RESP_OKAY;
      rdata_d = 32'h00000000;
      unique case (araddr)
        spi_core_pkg::CTRL_OFS: rdata_d = {11'h000, ctrl_q};
        spi_core_pkg::STAT_OFS: begin
          rdata_d[spi_core_pkg::RX_BUFFER_FULL_FLAG_B] = rx_buffer_full_flag_q;
          rdata_d[spi_core_pkg::TXE_B] = txe_q;
          rdata_d[spi_core_pkg::CRCERR_B] = crcerr_q;
          rdata_d[spi_core_pkg::MODF_B] = modf_q;
          rdata_d[spi_core_pkg::OVR_B] = ovr_q;
          rdata_d[spi_core_pkg::BSY_B] = bsy;
        end
        spi_core_pkg::DATA_OFS: begin
          rdata_d = {16'h0000, rx_buf_q};
          rd_data = 1'b1;
        end
        spi_core_pkg::POLY_OFS: rdata_d = {16'h0000, poly_q};
        spi_core_pkg::RXCRC_OFS: rdata_d = {16'h0000, rx_crc};
        spi_core_pkg::TXCRC_OFS: rdata_d = {16'h0000, tx_crc};
        default: rresp_d = spi_core_pkg::RESP_SLVERR;
      endcase
    end
    // hardware events are applied last so a set beats a same-cycle clear
    ovr_set = done_ev && rx_buffer_full_flag_q && !rd_data;
    if (done_ev && !ovr_set) begin
      rx_buf_d = rx_new;
    end
    rx_buffer_full_flag_d = (rx_buffer_full_flag_q && !rd_data) || done_ev;
    if (ovr_set) begin
      ovr_d = 1'b1;
    end
    if (load_buf) begin
      txe_d = 1'b1;
    end
    if (crc_bad) begin
      crcerr_d = 1'b1;
    end
    if (modf_ev) begin
      modf_d = 1'b1;
      ctrl_d[spi_core_pkg::MASTER_SELECT_B] = 1'b0;
      ctrl_d[spi_core_pkg::SPE_B] = 1'b0;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
    arready_d = !rvalid_d;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= spi_core_pkg::CTRL_RST;
      tx_buf_q <= '0;
      rx_buf_q <= '0;
      poly_q <= spi_core_pkg::POLY_RST;
      rx_buffer_full_flag_q <= 1'b0;
      txe_q <= 1'b1;
      crcerr_q <= 1'b0;
      modf_q <= 1'b0;
      ovr_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      waddr_q <= '0;
      wbuf_q <= '0;
      wstrb_q <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= spi_core_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= spi_core_pkg::RESP_OKAY;
      rdata <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      tx_buf_q <= tx_buf_d;
      rx_buf_q <= rx_buf_d;
      poly_q <= poly_d;
      rx_buffer_full_flag_q <= rx_buffer_full_flag_d;
      txe_q <= txe_d;
      crcerr_q <= crcerr_d;
      modf_q <= modf_d;
      ovr_q <= ovr_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      waddr_q <= waddr_d;
      wbuf_q <= wbuf_d;
      wstrb_q <= wstrb_d;
      awready <= awready_d;
      wready <= wready_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      arready <= arready_d;
      rvalid <= rvalid_d;
      rresp <= rresp_d;
      rdata <= rdata_d;
    end
  end
  assign sck_o = sck_q;
  assign sck_oe = sck_oe_q;
  assign mosi_o = out_q;
  assign miso_o = out_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_oe = miso_oe_q;
  assign nss_o = nss_o_q;
  assign nss_oe = nss_act_q;
  assign tx_dma_req = tx_dma_q;
  assign rx_dma_req = rx_dma_q;
  assign irq = irq_q;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // helper: serial clock edges made so far in the current master frame
  logic [5:0] edges_q, edges_d;
  always_comb begin
    edges_d = edges_q;
    if (!mst_run) begin
      edges_d = '0;
    end else if (sck_d != sck_q) begin
      edges_d = edges_q + 6'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edges_q <= '0;
    end else begin
      edges_q <= edges_d;
    end
  end
  property p_idle_pol;
    (state_q == spi_core_pkg::ST_IDLE) && $stable(clock_polarity) |=> sck_o == $past(clock_polarity);
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("sck not at idle level");
  property p_frame_len;
    done_ev && mst |-> edges_q == {width, 1'b0} - 6'h02 + {5'h00, clock_phase};
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_modf;
    modf_ev |=> !mst && modf_q && state_q == spi_core_pkg::ST_IDLE;
  endproperty
  a_modf: assert property (p_modf) else $error("mode fault not taken");
  property p_txe;
    load_buf |=> txe_q;
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty not set on load");
  property p_rx_buffer_full_flag;
    done_ev |=> rx_buffer_full_flag_q && (ovr_q || rx_buf_q == $past(rx_new));
  endproperty
  a_rx_buffer_full_flag: assert property (p_rx_buffer_full_flag) else $error("rx buffer not filled");
  property p_nss_out;
    nss_act_q && en && mst && hw_out |=> nss_oe && !nss_o;
  endproperty
  a_nss_out: assert property (p_nss_out) else $error("select output not low");
  property p_slave_pins;
    !mst ##1 !mst |-> !sck_oe && !mosi_oe;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave drives master pins");
  property p_soft_sel;
    en && mst && ctrl_q[spi_core_pkg::SSM_B] && ctrl_q[spi_core_pkg::SSI_B] && !do_wr |=> mst;
  endproperty
  a_soft_sel: assert property (p_soft_sel) else $error("soft select ignored");
endmodule
`default_nettype wire

// *** verif/spi_far_slave.sv ***
// far-side slave model: phase 0, polarity 0, msb first, 8-bit frames
`timescale 1ns/100ps
`default_nettype none
module spi_far_slave (
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] got
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] shown = 3'h0;
  logic [7:0] rx = 8'h00;
  // bit 7 stands before the first edge, as phase 0 needs; a stray falling
  // edge before reset only shows the same bit again
  assign miso = tx[3'h7 - shown];
  always @(posedge sck) begin
    rx <= {rx[6:0], mosi};
    cnt <= cnt + 3'h1;
    if (cnt == 3'h7) begin
      got <= {rx[6:0], mosi};
    end
  end
  always @(negedge sck) begin
    shown <= cnt;
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// bench for the serial core: registers, master and slave frames, mode fault
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [31:0] M = 32'h4;
  localparam logic [31:0] E = 32'h40;
  localparam logic [31:0] SI = 32'h300;
  localparam logic [31:0] SO = 32'h8000;
  localparam logic [31:0] IR = 32'hb0000;
  localparam logic [7:0] SD = 8'h5c;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, got;
  logic [31:0] wdata = 32'h0, rd_d;
  // responses are always accepted, so ready never has to drop between calls
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic nss_i = 1'b1, bm_sck = 1'b0, bm_mosi = 1'b0;
  logic [1:0] rsp;
  int checks = 0, n_mismatch = 0;
  wire logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, mosi_o, mosi_oe;
  wire logic miso_o, miso_oe, far_miso, nss_o, nss_oe, txd, rxd, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  // bench clock idles low when the core does not drive, as polarity 0 needs
  wire logic sck_w = sck_oe ? sck_o : bm_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : bm_mosi;
  wire logic miso_w = miso_oe ? miso_o : far_miso;
  always #10 clk = ~clk;
  spi_serial_core dut_u (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .nss_i(nss_i), .nss_o(nss_o), .nss_oe(nss_oe), .tx_dma_req(txd), .rx_dma_req(rxd),
    .irq(irq));
  spi_far_slave far_u (.sck(sck_w), .mosi(mosi_w), .tx(8'h35), .miso(far_miso), .got(got));
  // ----------------------------------------
  // bus tasks: handshakes judged at negedge, changes made after posedge
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid;
      rd_d = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_reset;
    rd(spi_core_pkg::STAT_OFS);
    chk("stat reset", 32'h2, rd_d);
    rd(spi_core_pkg::POLY_OFS);
    chk("poly reset", 32'h7, rd_d);
    chk("irq dma idle", 32'h0, {29'h0, irq, txd, rxd});
    rd(8'h20);
    chk("unmapped rd", 32'h2, {30'h0, rsp});
    wr(8'h20, 32'h1);
    chk("unmapped wr", 32'h2, {30'h0, rsp});
  endtask
  task automatic t_master(input logic lsb);
    int i;
    wr(spi_core_pkg::CTRL_OFS, 32'h0);
    // lsb run drives the select pin from hardware instead of the soft level
    wr(spi_core_pkg::CTRL_OFS, M | E | IR | 32'h18 | (lsb ? SO : SI) | {24'h0, lsb, 7'h0});
    nss_i <= 1'b0;
    @(negedge clk);
    chk("sck idle", 32'h0, {31'h0, sck_o});
    chk("pin enables", 32'h6, {29'h0, sck_oe, mosi_oe, miso_oe});
    @(posedge clk);
    wr(spi_core_pkg::DATA_OFS, 32'h96);
    rd_d = 32'h0;
    for (i = 0; i < 100 && rd_d[0] !== 1'b1; i++) rd(spi_core_pkg::STAT_OFS);
    chk("rx ready", 32'h1, {31'h0, rd_d[0]});
    chk("irq dma set", 32'h7, {29'h0, irq, txd, rxd});
    chk("select pin", lsb ? 32'h2 : 32'h1, {30'h0, nss_oe, nss_o});
    rd(spi_core_pkg::DATA_OFS);
    chk("rx word", lsb ? 32'hac : 32'h35, rd_d);
    chk("far word", lsb ? 32'h69 : 32'h96, {24'h0, got});
    rd(spi_core_pkg::STAT_OFS);
    chk("rx full", 32'h0, {31'h0, rd_d[0]});
    chk("irq dma clear", 32'h2, {29'h0, irq, txd, rxd});
    nss_i <= 1'b1;
  endtask
  task automatic t_slave;
    int i;
    logic [7:0] so;
    wr(spi_core_pkg::CTRL_OFS, 32'h0);
    wr(spi_core_pkg::DATA_OFS, 32'ha5);
    wr(spi_core_pkg::CTRL_OFS, E | 32'h18);
    nss_i <= 1'b0;
    repeat (8) @(posedge clk);
    // bench acts as master: phase 0, 8 clocks per half period
    for (i = 7; i >= 0; i--) begin
      bm_mosi <= SD[i];
      repeat (7) @(posedge clk);
      @(negedge clk);
      so[i] = miso_w;
      @(posedge clk);
      bm_sck <= 1'b1;
      repeat (8) @(posedge clk);
      bm_sck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    nss_i <= 1'b1;
    rd(spi_core_pkg::DATA_OFS);
    chk("slave rx", 32'h5c, rd_d);
    chk("slave tx", 32'ha5, {24'h0, so});
  endtask
  task automatic t_fault;
    wr(spi_core_pkg::CTRL_OFS, 32'h0);
    wr(spi_core_pkg::CTRL_OFS, M | E);
    nss_i <= 1'b0;
    repeat (6) @(posedge clk);
    rd(spi_core_pkg::CTRL_OFS);
    chk("master cleared", 32'h0, rd_d & (M | E));
    chk("sck released", 32'h0, {31'h0, sck_oe});
    rd(spi_core_pkg::STAT_OFS);
    chk("fault flag", 32'h20, rd_d & 32'h20);
    wr(spi_core_pkg::STAT_OFS, 32'h20);
    rd(spi_core_pkg::STAT_OFS);
    chk("fault cleared", 32'h0, rd_d & 32'h20);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_master(1'b0);
    t_master(1'b1);
    t_slave();
    t_fault();
    give_verdict();
  end
endmodule
`default_nettype wire
